/* File: per_periph_end.sv */
`timescale 1ns/1ps
module per_periph_end (
  input wire logic ref_clk,
  input wire logic nrst,
  per_router_if.periph bus,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [per_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [per_pkg::DATA_W-1:0] cmd_wdata,
  output logic [per_pkg::DATA_W-1:0] cmd_rdata,
  output logic cmd_rdata_valid,
  input wire logic [per_pkg::ASYNC_GEN_W-1:0] gen_async_in,
  input wire logic [per_pkg::SYNC_GEN_W-1:0] gen_sync_in,
  input wire logic events_on,
  input wire logic [per_pkg::N_PIN-1:0] pin_enable,
  output logic [per_pkg::N_ASYNC_USER-1:0] use_async_out,
  output logic [per_pkg::N_SYNC_USER-1:0] use_sync_out,
  output logic [per_pkg::N_PIN-1:0] pin_out,
  output logic [per_pkg::N_PIN-1:0] pin_oe
);
  import per_pkg::*;

  // ----------------------------------------------------------------
  // Register access towards the router
  // ----------------------------------------------------------------
  logic wr_q;
  logic rd_q;
  logic rd_q2;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      rd_q2 <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
      cmd_rdata <= READ_ZERO;
      cmd_rdata_valid <= 1'b0;
    end else begin
      wr_q <= cmd_wr;
      rd_q <= cmd_rd && !cmd_wr;
      rd_q2 <= rd_q;
      cmd_rdata_valid <= rd_q2;
      if (cmd_wr || cmd_rd) begin
        addr_q <= cmd_addr;
        wdata_q <= cmd_wdata;
      end
      if (rd_q2) begin
        cmd_rdata <= bus.reg_rdata;
      end
    end
  end

  assign bus.reg_wr = wr_q;
  assign bus.reg_rd = rd_q;
  assign bus.reg_addr = addr_q;
  assign bus.reg_wdata = wdata_q;

  // ----------------------------------------------------------------
  // Generators pass straight in, pulse or level alike
  // ----------------------------------------------------------------
  assign bus.async_gen = gen_async_in;
  assign bus.sync_gen = gen_sync_in;

  // ----------------------------------------------------------------
  // Consumers
  // ----------------------------------------------------------------
  logic [N_ASYNC_USER-1:0] async_meta;
  logic [N_ASYNC_USER-1:0] async_sync;
  logic [N_PIN-1:0] pin_en_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      async_meta <= '0;
      async_sync <= '0;
      use_async_out <= '0;
      use_sync_out <= '0;
      pin_en_q <= '0;
    end else begin
      async_meta <= bus.async_use;
      async_sync <= async_meta;
      use_async_out <= events_on ? async_sync : '0;
      use_sync_out <= events_on ? bus.sync_use : '0;
      pin_en_q <= pin_enable;
    end
  end

  // Pin path stays asynchronous; only the enable is clocked
  assign pin_out = bus.event_pin_output & pin_en_q;
  assign pin_oe = pin_en_q;

endmodule // per_periph_end

/* File: per_pkg.sv */
package per_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int N_ASYNC_CH = 4;
  localparam int N_SYNC_CH = 2;
  localparam int N_ASYNC_USER = 11;
  localparam int N_SYNC_USER = 2;
  localparam int N_PIN = 3;
  localparam int PIN_USER_BASE = 8;
  localparam int ASYNC_GEN_W = 18;
  localparam int SYNC_GEN_W = 20;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_ASYNC_STROBE = 6'h00;
  localparam logic [ADDR_W-1:0] REG_SYNC_STROBE = 6'h01;
  localparam logic [ADDR_W-1:0] REG_ASYNC_SRC0 = 6'h02;
  localparam logic [ADDR_W-1:0] REG_SYNC_SRC0 = 6'h0a;
  localparam logic [ADDR_W-1:0] REG_ASYNC_USER0 = 6'h12;
  localparam logic [ADDR_W-1:0] REG_SYNC_USER0 = 6'h22;

  // ----------------------------------------------------------------
  // Selector encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] SEL_OFF = 8'h00;
  localparam logic [DATA_W-1:0] ASYNC_GEN_MAX = 8'h12;
  localparam logic [DATA_W-1:0] SYNC_GEN_MAX = 8'h14;
  localparam logic [DATA_W-1:0] USER_SYNC_CH0 = 8'h01;
  localparam logic [DATA_W-1:0] USER_ASYNC_CH0 = 8'h03;
  localparam logic [DATA_W-1:0] RESET_SEL = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

  typedef logic [DATA_W-1:0] per_sel_t;

endpackage

/* File: per_router.sv */
`timescale 1ns/1ps

// How it works
// - Four async and two sync parallel channels.
// - Each channel carries one chosen generator.
// - One channel feeds any number of consumers.
// - Pulses and levels pass through unchanged.
// - Three channels drive pin event outputs.
// - Consumers eight to ten pick pin channels.
// - Pin unit enable bit gates pins.
// - Every consumer owns one channel multiplexer.
// - Async consumers take sync channels too.
// - Consumer multiplexers reset to off.
// - Per-channel source selector, reset disconnected.
// - Strobe write inverts channel one cycle.
// - Soft event looks like generator event.
// - Registers clocked; routing needs no clock.
// - No soft events while clock stopped.
// - Debug halt changes nothing.
// - Async consumers synchronise events themselves.
// - Configure routing before enabling consumers.
module per_router (
  input wire logic ref_clk,
  input wire logic nrst,
  per_router_if.router bus
);
  import per_pkg::*;

  // ----------------------------------------------------------------
  // Selection functions
  // ----------------------------------------------------------------
  function automatic logic pick_async_gen(per_sel_t sel, logic [ASYNC_GEN_W-1:0] gen);
    logic hit;
    hit = 1'b0;
    if (sel != SEL_OFF && sel <= ASYNC_GEN_MAX) begin
      hit = gen[5'(sel - 8'h01)];
    end
    return hit;
  endfunction

  function automatic logic pick_sync_gen(per_sel_t sel, logic [SYNC_GEN_W-1:0] gen);
    logic hit;
    hit = 1'b0;
    if (sel != SEL_OFF && sel <= SYNC_GEN_MAX) begin
      hit = gen[5'(sel - 8'h01)];
    end
    return hit;
  endfunction

  function automatic logic pick_user_chan(per_sel_t sel, logic [N_SYNC_CH-1:0] sch,
                                          logic [N_ASYNC_CH-1:0] ach, logic allow_async);
    logic hit;
    hit = 1'b0;
    for (int c = 0; c < N_SYNC_CH; c++) begin
      if (sel == USER_SYNC_CH0 + DATA_W'(c)) begin
        hit = sch[c];
      end
    end
    if (allow_async) begin
      for (int c = 0; c < N_ASYNC_CH; c++) begin
        if (sel == USER_ASYNC_CH0 + DATA_W'(c)) begin
          hit = ach[c];
        end
      end
    end
    return hit;
  endfunction

  // ----------------------------------------------------------------
  // Configuration state
  // ----------------------------------------------------------------
  per_sel_t async_src [N_ASYNC_CH];
  per_sel_t sync_src [N_SYNC_CH];
  per_sel_t async_user [N_ASYNC_USER];
  per_sel_t sync_user [N_SYNC_USER];
  logic [N_ASYNC_CH-1:0] async_strobe;
  logic [N_SYNC_CH-1:0] sync_strobe;
  logic [DATA_W-1:0] rdata;

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  wire wr_async_strobe = bus.reg_wr && bus.reg_addr == REG_ASYNC_STROBE;
  wire wr_sync_strobe = bus.reg_wr && bus.reg_addr == REG_SYNC_STROBE;
  wire [N_ASYNC_CH-1:0] next_async_strobe = wr_async_strobe ? bus.reg_wdata[N_ASYNC_CH-1:0] : '0;
  wire [N_SYNC_CH-1:0] next_sync_strobe = wr_sync_strobe ? bus.reg_wdata[N_SYNC_CH-1:0] : '0;

  // Strobes last exactly one clock; a stopped clock makes none
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      async_strobe <= '0;
      sync_strobe <= '0;
    end else begin
      async_strobe <= next_async_strobe;
      sync_strobe <= next_sync_strobe;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < N_ASYNC_CH; gi++) begin : g_async_src
      wire wr_hit = bus.reg_wr && bus.reg_addr == REG_ASYNC_SRC0 + ADDR_W'(gi);
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          async_src[gi] <= RESET_SEL;
        end else if (wr_hit) begin
          async_src[gi] <= bus.reg_wdata;
        end
      end
    end
    for (gi = 0; gi < N_SYNC_CH; gi++) begin : g_sync_src
      wire wr_hit = bus.reg_wr && bus.reg_addr == REG_SYNC_SRC0 + ADDR_W'(gi);
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          sync_src[gi] <= RESET_SEL;
        end else if (wr_hit) begin
          sync_src[gi] <= bus.reg_wdata;
        end
      end
    end
    for (gi = 0; gi < N_ASYNC_USER; gi++) begin : g_async_user
      wire wr_hit = bus.reg_wr && bus.reg_addr == REG_ASYNC_USER0 + ADDR_W'(gi);
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          async_user[gi] <= RESET_SEL;
        end else if (wr_hit) begin
          async_user[gi] <= bus.reg_wdata;
        end
      end
    end
    for (gi = 0; gi < N_SYNC_USER; gi++) begin : g_sync_user
      wire wr_hit = bus.reg_wr && bus.reg_addr == REG_SYNC_USER0 + ADDR_W'(gi);
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          sync_user[gi] <= RESET_SEL;
        end else if (wr_hit) begin
          sync_user[gi] <= bus.reg_wdata;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  function automatic per_sel_t read_reg(logic [ADDR_W-1:0] addr);
    per_sel_t rv;
    rv = READ_ZERO;
    for (int i = 0; i < N_ASYNC_CH; i++) begin
      if (addr == REG_ASYNC_SRC0 + ADDR_W'(i)) begin
        rv = async_src[i];
      end
    end
    for (int i = 0; i < N_SYNC_CH; i++) begin
      if (addr == REG_SYNC_SRC0 + ADDR_W'(i)) begin
        rv = sync_src[i];
      end
    end
    for (int i = 0; i < N_ASYNC_USER; i++) begin
      if (addr == REG_ASYNC_USER0 + ADDR_W'(i)) begin
        rv = async_user[i];
      end
    end
    for (int i = 0; i < N_SYNC_USER; i++) begin
      if (addr == REG_SYNC_USER0 + ADDR_W'(i)) begin
        rv = sync_user[i];
      end
    end
    return rv;
  endfunction

  // Process, so a write under a steady address is seen
  logic [DATA_W-1:0] next_rdata;
  always_comb begin
    next_rdata = read_reg(bus.reg_addr);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= READ_ZERO;
    end else if (bus.reg_rd) begin
      rdata <= next_rdata;
    end
  end

  assign bus.reg_rdata = rdata;

  // ----------------------------------------------------------------
  // Routing network, no clock in the path
  // ----------------------------------------------------------------
  logic [N_ASYNC_CH-1:0] async_chan;
  logic [N_SYNC_CH-1:0] sync_chan;

  generate
    for (gi = 0; gi < N_ASYNC_CH; gi++) begin : g_async_chan
      // Strobe inverts whatever the generator shows
      assign async_chan[gi] = pick_async_gen(async_src[gi], bus.async_gen) ^ async_strobe[gi];
    end
    for (gi = 0; gi < N_SYNC_CH; gi++) begin : g_sync_chan
      assign sync_chan[gi] = pick_sync_gen(sync_src[gi], bus.sync_gen) ^ sync_strobe[gi];
    end
    for (gi = 0; gi < N_ASYNC_USER; gi++) begin : g_async_use
      assign bus.async_use[gi] = pick_user_chan(async_user[gi], sync_chan, async_chan, 1'b1);
    end
    for (gi = 0; gi < N_SYNC_USER; gi++) begin : g_sync_use
      assign bus.sync_use[gi] = pick_user_chan(sync_user[gi], sync_chan, async_chan, 1'b0);
    end
    for (gi = 0; gi < N_PIN; gi++) begin : g_pin
      // Pin consumers share the async consumer multiplexers
      assign bus.event_pin_output[gi] = bus.async_use[PIN_USER_BASE + gi];
    end
  endgenerate

endmodule // per_router

/* File: per_router_if.sv */
`timescale 1ns/1ps
interface per_router_if;
  import per_pkg::*;

  logic reg_wr;
  logic reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic [ASYNC_GEN_W-1:0] async_gen;
  logic [SYNC_GEN_W-1:0] sync_gen;
  logic [N_ASYNC_USER-1:0] async_use;
  logic [N_SYNC_USER-1:0] sync_use;
  logic [N_PIN-1:0] event_pin_output;

  modport router (
    input reg_wr,
    input reg_rd,
    input reg_addr,
    input reg_wdata,
    output reg_rdata,
    input async_gen,
    input sync_gen,
    output async_use,
    output sync_use,
    output event_pin_output
  );

  modport periph (
    output reg_wr,
    output reg_rd,
    output reg_addr,
    output reg_wdata,
    input reg_rdata,
    output async_gen,
    output sync_gen,
    input async_use,
    input sync_use,
    input event_pin_output
  );

endinterface

/* File: per_router_sva.sv */
`timescale 1ns/1ps
module per_router_sva (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [per_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [per_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [per_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [per_pkg::ASYNC_GEN_W-1:0] async_gen,
  input wire logic [per_pkg::SYNC_GEN_W-1:0] sync_gen,
  input wire logic [per_pkg::N_ASYNC_USER-1:0] async_use,
  input wire logic [per_pkg::N_SYNC_USER-1:0] sync_use,
  input wire logic [per_pkg::N_PIN-1:0] event_pin_output
);
  import per_pkg::*;
  // ----
  // Router checks
  // ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  rst_off_a: assert property ($rose(nrst) |-> async_use == '0 && sync_use == '0)
    else $error("consumer active after reset");
  rd_unmapped_a: assert property (
    reg_rd && !(reg_addr inside {[6'h02:6'h05], [6'h0a:6'h0b], [6'h12:6'h1c], [6'h22:6'h23]})
    |=> reg_rdata == READ_ZERO) else $error("unmapped read not zero");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  user_back_a: assert property (
    reg_wr && reg_addr == REG_ASYNC_USER0 ##1 !reg_wr ##1 reg_rd && reg_addr == REG_ASYNC_USER0
    |=> reg_rdata == $past(reg_wdata, 3)) else $error("consumer select readback wrong");
  strobe_back_a: assert property (
    reg_wr && reg_addr <= REG_SYNC_STROBE && !$past(reg_wr)
    ##1 (!reg_wr && $stable(async_gen) && $stable(sync_gen)) [*2]
    |-> async_use == $past(async_use, 2) && sync_use == $past(sync_use, 2))
    else $error("strobe not one cycle");
  route_static_a: assert property (
    !$past(reg_wr) && !$past(reg_wr, 2) && $stable(async_gen) && $stable(sync_gen)
    |-> $stable(async_use) && $stable(sync_use)) else $error("routing changed by itself");
  pin_match_a: assert property (event_pin_output == async_use[PIN_USER_BASE +: N_PIN])
    else $error("pin output not consumer eight to ten");
  async_iso_a: assert property (
    reg_wr && reg_addr == REG_ASYNC_STROBE && !$past(reg_wr) ##1 !reg_wr && $stable(sync_gen)
    |-> $stable(sync_use)) else $error("async strobe reached sync consumer");
endmodule // per_router_sva

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
  import per_pkg::*;
  logic ref_clk = 0, nrst = 0, cmd_wr = 0, cmd_rd = 0, events_on = 0, cmd_rdata_valid;
  logic [ADDR_W-1:0] cmd_addr = '0;
  logic [DATA_W-1:0] cmd_wdata = '0, cmd_rdata;
  logic [ASYNC_GEN_W-1:0] gen_async_in = '0;
  logic [SYNC_GEN_W-1:0] gen_sync_in = '0;
  logic [N_PIN-1:0] pin_enable = '0, pin_out, pin_oe;
  logic [N_ASYNC_USER-1:0] use_async_out;
  logic [N_SYNC_USER-1:0] use_sync_out;
  logic [7:0] mem [64] = '{default: 8'h00};
  int n_fail = 0, n_compared = 0;
  per_router_if bus_if ();
  per_router per_router_inst (.ref_clk(ref_clk), .nrst(nrst), .bus(bus_if.router));
  per_periph_end per_periph_end_inst (.ref_clk(ref_clk), .nrst(nrst), .bus(bus_if.periph),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_rdata(cmd_rdata), .cmd_rdata_valid(cmd_rdata_valid), .gen_async_in(gen_async_in),
    .gen_sync_in(gen_sync_in), .events_on(events_on), .pin_enable(pin_enable),
    .use_async_out(use_async_out), .use_sync_out(use_sync_out), .pin_out(pin_out), .pin_oe(pin_oe));
  per_router_sva per_router_sva_inst (.ref_clk(ref_clk), .nrst(nrst), .reg_wr(bus_if.reg_wr),
    .reg_rd(bus_if.reg_rd), .reg_addr(bus_if.reg_addr), .reg_wdata(bus_if.reg_wdata),
    .reg_rdata(bus_if.reg_rdata), .async_gen(bus_if.async_gen), .sync_gen(bus_if.sync_gen),
    .async_use(bus_if.async_use), .sync_use(bus_if.sync_use), .event_pin_output(bus_if.event_pin_output));
  always #10 ref_clk = ~ref_clk;
  // ----
  // Model and checks
  // ----
  function automatic logic usr(logic [7:0] v, bit a);
    logic [7:0] s;
    if (v == 8'h01 || v == 8'h02) begin
      s = mem[8'h0a + v - 8'h01];
      return (s >= 8'h01 && s <= 8'h14) ? gen_sync_in[s - 8'h01] : 1'b0;
    end
    if (!a || v < 8'h03 || v > 8'h06)
      return 1'b0;
    s = mem[v - 8'h01];
    return (s >= 8'h01 && s <= 8'h12) ? gen_async_in[s - 8'h01] : 1'b0;
  endfunction
  task automatic cmp_out(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_reg(int a, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR reg %0h expected %h seen %h", a, e, g);
    end
  endtask
  task automatic wr(int a, logic [7:0] d);
    @(posedge ref_clk);
    #1 cmd_wr = 1;
    cmd_addr = ADDR_W'(a);
    cmd_wdata = d;
    @(posedge ref_clk);
    #1 cmd_wr = 0;
    if (a inside {[2:5], [10:11], [18:28], [34:35]})
      mem[a] = d;
  endtask
  task automatic rd(int a);
    @(posedge ref_clk);
    #1 cmd_rd = 1;
    cmd_addr = ADDR_W'(a);
    @(posedge ref_clk);
    #1 cmd_rd = 0;
    repeat (2) @(posedge ref_clk);
    #1;
    cmp_out("rd_valid", 1, cmd_rdata_valid);
    cmp_reg(a, mem[a], cmd_rdata);
  endtask
  task automatic chk_use();
    logic [N_ASYNC_USER-1:0] ea;
    logic [N_SYNC_USER-1:0] es;
    repeat (6) @(posedge ref_clk);
    #1;
    for (int i = 0; i < N_ASYNC_USER; i++) ea[i] = usr(mem[18 + i], 1);
    for (int i = 0; i < N_SYNC_USER; i++) es[i] = usr(mem[34 + i], 0);
    cmp_out("pin_out", ea[PIN_USER_BASE +: N_PIN] & pin_enable, pin_out);
    cmp_out("use_async", ea & {N_ASYNC_USER{events_on}}, use_async_out);
    cmp_out("use_sync", es & {N_SYNC_USER{events_on}}, use_sync_out);
    cmp_out("pin_oe", pin_enable, pin_oe);
  endtask
  task automatic strb(int a, logic [7:0] d, int b, bit s, int e);
    int n = 0;
    wr(a, d);
    repeat (10) begin
      @(posedge ref_clk);
      #1;
      n += ((s ? use_sync_out[b] : use_async_out[b]) === 1'b1);
    end
    cmp_out("strobe_pulses", e, n);
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #400000;
    n_fail++;
    end_sim();
  end
  initial begin
    void'($urandom(73625));
    repeat (3) @(posedge ref_clk);
    #1 nrst = 1;
    for (int a = 0; a < 36; a++) rd(a);
    $display("test reset done");
    for (int r = 0; r < 6; r++) begin
      for (int a = 0; a < 36; a++) wr(a, 8'($urandom % 24));
      for (int a = 2; a < 36; a++) rd(a);
      gen_async_in = ASYNC_GEN_W'($urandom);
      gen_sync_in = SYNC_GEN_W'($urandom);
      pin_enable = N_PIN'($urandom);
      events_on = (r != 2);
      chk_use();
      $display("test route %0d done", r);
    end
    gen_async_in = '0;
    gen_sync_in = '0;
    events_on = 1;
    foreach (mem[a]) if (a inside {[2:5], [10:11]}) wr(a, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(18, 8'(3 + c));
      rd(18);
      strb(0, 8'(1 << c), 0, 0, 1);
    end
    strb(0, 8'hf0, 0, 0, 0);
    for (int c = 0; c < 2; c++) begin
      wr(34, 8'(1 + c));
      strb(1, 8'(1 << c), 0, 1, 1);
    end
    $display("test strobe done");
    @(posedge ref_clk);
    #1 cmd_wr = 1;
    cmd_rd = 1;
    cmd_addr = ADDR_W'(35);
    cmd_wdata = 8'h05;
    @(posedge ref_clk);
    #1 cmd_wr = 0;
    cmd_rd = 0;
    mem[35] = 8'h05;
    repeat (2) @(posedge ref_clk);
    #1;
    cmp_out("rd_dropped", 0, cmd_rdata_valid);
    rd(35);
    $display("test refused read done");
    nrst = 0;
    @(posedge ref_clk);
    #1 nrst = 1;
    foreach (mem[a]) mem[a] = 8'h00;
    for (int a = 2; a < 36; a++) rd(a);
    chk_use();
    $display("test second reset done");
    end_sim();
  end
endmodule // testbench
